/* gpio_board.sv */
// Board wiring of one port: pull-ups and external drivers on the pins.
`timescale 1ns/10ps
module gpio_board #(
  parameter W = 8
) (
  input  wire [W-1:0] pin_o,
  input  wire [W-1:0] pin_oe_n,
  input  wire [W-1:0] ext_en,
  input  wire [W-1:0] ext_v,
  output wire [W-1:0] pin_i
);
  // A driven pin shows the latch; a released pin shows the external driver or the pull-up.
  assign pin_i = (~pin_oe_n & pin_o) | (pin_oe_n & ((ext_en & ext_v) | ~ext_en));
endmodule

/* gpio_fall_flag.v */
// Sticky flag set by a falling edge of a level, cleared by software.
`timescale 1ns/10ps
module gpio_fall_flag (
  input  wire aclk,
  input  wire aresetn,
  input  wire level,
  input  wire clr,
  output reg  flag_reg
);
  reg prev_reg;

  // ****************************************************************************
  // Edge detect; a new edge wins over a clear in the same cycle.
  // ****************************************************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      prev_reg <= 1'b1;
      flag_reg <= 1'b0;
    end else begin
      prev_reg <= level;
      if (prev_reg && !level) begin
        flag_reg <= 1'b1;  // see RULE11
      end else if (clr) begin
        flag_reg <= 1'b0;
      end
    end
  end
endmodule

/* gpio_map.vh */
// Register map, field positions and reset values of the general-purpose ports.
// ****************************************************************************
// Overview of operation
// RULE1 - Output paths hold a latched value; inputs are sampled live, never latched.
// RULE2 - Pin levels are sampled in the first state of the read cycle.
// RULE3 - Write data enters the port latches in the second state of writing.
// RULE4 - Read-modify-write class reads return the latch; other reads return pins. Here input-mode bits without open-drain return pins.
// RULE5 - Port one has direction and data registers, both reset to zero.
// RULE6 - Port one reads give undefined values in bits seven and six.
// RULE7 - Port two output latch resets to all ones.
// RULE8 - Software keeps a port two latch bit one when that pin is input.
// RULE9 - Port two reads give undefined values in bits seven down to three.
// RULE10 - Port two read-modify-write reads the latch; other reads read the pins.
// RULE11 - A falling edge on the driven stop-release pin still sets its interrupt latch.
// RULE12 - In stop mode the stop-release pin floats, whatever the output-hold enable.
// RULE13 - Port three has direction and data registers, both reset to zero.
// RULE14 - Each port three direction bit selects input at zero, output at one.
// RULE15 - Port three open-drain select: zero tri-state, one open-drain, reset zero.
// RULE16 - Open-drain bits on ports three and four read latch for read-modify-write.
// RULE17 - Software sets a port three latch bit before motor waveform output.
// RULE18 - Software disables the emergency-stop input before plain port three use.
// RULE19 - Port four has direction and data registers, both reset to zero.
// RULE20 - Port four open-drain control register resets to zero, tri-state.
// RULE21 - Software sets the timer pin to output mode for ordinary timer use.
// RULE22 - Writes to unimplemented upper bits of ports one and two are ignored.
// ****************************************************************************
`ifndef GPIO_MAP_VH
`define GPIO_MAP_VH
// Register indices; the byte address is four times the index.
`define GPIO_IDX_P1_DATA  13'h0001
`define GPIO_IDX_P2_DATA  13'h0002
`define GPIO_IDX_P3_DATA  13'h0003
`define GPIO_IDX_P4_DATA  13'h0004
`define GPIO_IDX_P1_DIR   13'h000B
`define GPIO_IDX_SYSCTL   13'h0038
`define GPIO_IDX_EDGE     13'h0040
`define GPIO_IDX_P3_OD    13'h1F83
`define GPIO_IDX_P4_OD    13'h1F84
`define GPIO_IDX_P3_DIR   13'h1F89
`define GPIO_IDX_P4_DIR   13'h1F8A
// Address bit that selects the read-modify-write read window.
`define GPIO_RMW_BIT      15
// Fields of the system control register.
`define GPIO_SYS_STOP_OUTPUT_HOLD_ENABLE    4
`define GPIO_SYS_STOP     7
// Widths and reset values.
`define GPIO_P1_W         6
`define GPIO_P2_W         3
`define GPIO_P34_W        8
`define GPIO_P1_RST       6'h00
`define GPIO_P2_RST       3'h7
`define GPIO_P34_RST      8'h00
`define GPIO_SYS_RST      8'h00
`define GPIO_RESP_OKAY    2'h0
`define GPIO_RESP_SLVERR  2'h2
`endif

/* gpio_port.v */
// One general-purpose port: data latch, direction, open-drain select and pin drive.
`timescale 1ns/10ps
module gpio_port #(
  parameter         W       = 8,
  parameter [W-1:0] RST_DAT = {W{1'b0}},
  parameter [W-1:0] RST_DIR = {W{1'b0}},
  parameter [W-1:0] RST_OD  = {W{1'b0}}
) (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire [W-1:0] wdata,
  input  wire         wr_data,
  input  wire         wr_dir,
  input  wire         wr_od,
  input  wire [W-1:0] stop_hiz,
  input  wire [W-1:0] pin_i,
  output reg  [W-1:0] data_reg,
  output reg  [W-1:0] dir_reg,
  output reg  [W-1:0] od_reg,
  output wire [W-1:0] rmw_val,
  output wire [W-1:0] pin_o,
  output wire [W-1:0] pin_oe_n
);
  // ****************************************************************************
  // Registers.
  // ****************************************************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      data_reg <= RST_DAT;
      dir_reg  <= RST_DIR;
      od_reg   <= RST_OD;
    end else begin
      if (wr_data) begin
        data_reg <= wdata;  // see RULE1, see RULE3
      end
      if (wr_dir) begin
        dir_reg <= wdata;   // see RULE14
      end
      if (wr_od) begin
        od_reg <= wdata;    // see RULE15
      end
    end
  end

  // ****************************************************************************
  // Pin drive and read-back.
  // ****************************************************************************
  // An open-drain bit drives only a low level; a stop-forced bit never drives.
  assign pin_oe_n = ~(dir_reg & ~stop_hiz & (~od_reg | ~data_reg));  // see RULE14, see RULE15
  assign pin_o    = data_reg;
  assign rmw_val  = ((dir_reg | od_reg) & data_reg) | (~(dir_reg | od_reg) & pin_i);  // see RULE16
endmodule

/* gpio_ports.v */
// Four general-purpose ports with an AXI4-Lite register slave.
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/10ps
`include "gpio_map.vh"
module gpio_ports (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [15:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [15:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [5:0]  port1_pin_i,
  output wire [5:0]  port1_pin_o,
  output wire [5:0]  port1_pin_oe_n,
  input  wire [2:0]  port2_pin_i,
  output wire [2:0]  port2_pin_o,
  output wire [2:0]  port2_pin_oe_n,
  input  wire [7:0]  port3_pin_i,
  output wire [7:0]  port3_pin_o,
  output wire [7:0]  port3_pin_oe_n,
  input  wire [7:0]  port4_pin_i,
  output wire [7:0]  port4_pin_o,
  output wire [7:0]  port4_pin_oe_n,
  output wire        stop_release_irq
);
  // ****************************************************************************
  // Write channel capture.
  // ****************************************************************************
  reg        aw_full_reg;
  reg [15:0] awaddr_reg;
  reg        w_full_reg;
  reg [7:0]  wbyte_reg;
  reg        wlane_reg;
  reg        bvalid_reg;
  reg [1:0]  bresp_reg;
  reg        rvalid_reg;
  reg [1:0]  rresp_reg;
  reg [7:0]  rbyte_reg;
  reg [7:0]  sysctl_reg;

  wire       do_write;
  wire [12:0] widx;
  wire       wwin;
  wire       wr_p1d;
  wire       wr_p2d;
  wire       wr_p3d;
  wire       wr_p4d;
  wire       wr_p1c;
  wire       wr_p3c;
  wire       wr_p4c;
  wire       wr_p3o;
  wire       wr_p4o;
  wire       wr_sys;
  wire       wr_edge;
  wire       whit;

  assign s_axi_awready = ~aw_full_reg;
  assign s_axi_wready  = ~w_full_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;

  // Both halves present forms the second state, in which the latches load.
  assign do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
  assign widx     = awaddr_reg[14:2];
  assign wwin     = do_write & ~awaddr_reg[`GPIO_RMW_BIT] & wlane_reg;
  assign wr_p1d   = wwin & (widx == `GPIO_IDX_P1_DATA);
  assign wr_p2d   = wwin & (widx == `GPIO_IDX_P2_DATA);
  assign wr_p3d   = wwin & (widx == `GPIO_IDX_P3_DATA);
  assign wr_p4d   = wwin & (widx == `GPIO_IDX_P4_DATA);
  assign wr_p1c   = wwin & (widx == `GPIO_IDX_P1_DIR);
  assign wr_p3c   = wwin & (widx == `GPIO_IDX_P3_DIR);
  assign wr_p4c   = wwin & (widx == `GPIO_IDX_P4_DIR);
  assign wr_p3o   = wwin & (widx == `GPIO_IDX_P3_OD);
  assign wr_p4o   = wwin & (widx == `GPIO_IDX_P4_OD);
  assign wr_sys   = wwin & (widx == `GPIO_IDX_SYSCTL);
  assign wr_edge  = wwin & (widx == `GPIO_IDX_EDGE);
  assign whit     = ~awaddr_reg[`GPIO_RMW_BIT] & ((widx == `GPIO_IDX_P1_DATA) |
                    (widx == `GPIO_IDX_P2_DATA) | (widx == `GPIO_IDX_P3_DATA) |
                    (widx == `GPIO_IDX_P4_DATA) | (widx == `GPIO_IDX_P1_DIR) |
                    (widx == `GPIO_IDX_P3_DIR) | (widx == `GPIO_IDX_P4_DIR) |
                    (widx == `GPIO_IDX_P3_OD) | (widx == `GPIO_IDX_P4_OD) |
                    (widx == `GPIO_IDX_SYSCTL) | (widx == `GPIO_IDX_EDGE));

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      awaddr_reg  <= 16'h0000;
      w_full_reg  <= 1'b0;
      wbyte_reg   <= 8'h00;
      wlane_reg   <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `GPIO_RESP_OKAY;
      sysctl_reg  <= `GPIO_SYS_RST;
    end else begin
      if (s_axi_awvalid && !aw_full_reg) begin
        aw_full_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full_reg) begin
        w_full_reg <= 1'b1;
        wbyte_reg  <= s_axi_wdata[7:0];
        wlane_reg  <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= whit ? `GPIO_RESP_OKAY : `GPIO_RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
      if (wr_sys) begin
        sysctl_reg <= wbyte_reg;
      end
    end
  end

  // ****************************************************************************
  // Stop-mode pin release.
  // ****************************************************************************
  wire stop_mode;
  wire stop_output_hold_enable;
  wire hold_off;

  assign stop_mode = sysctl_reg[`GPIO_SYS_STOP];
  assign stop_output_hold_enable     = sysctl_reg[`GPIO_SYS_STOP_OUTPUT_HOLD_ENABLE];
  assign hold_off  = stop_mode & ~stop_output_hold_enable;

  // ****************************************************************************
  // Ports.
  // ****************************************************************************
  wire [5:0] p1_dat;
  wire [5:0] p1_dir;
  wire [5:0] p1_rmw;
  wire [2:0] p2_dat;
  wire [2:0] p2_rmw;
  wire [7:0] p3_dat;
  wire [7:0] p3_dir;
  wire [7:0] p3_od;
  wire [7:0] p3_rmw;
  wire [7:0] p4_dat;
  wire [7:0] p4_dir;
  wire [7:0] p4_od;
  wire [7:0] p4_rmw;
  wire [2:0] p2_hiz;

  // Only the low bits of a narrow port are stored; upper bits are dropped.
  gpio_port #(
    .W       (`GPIO_P1_W),
    .RST_DAT (`GPIO_P1_RST),
    .RST_DIR (`GPIO_P1_RST),
    .RST_OD  (`GPIO_P1_RST)
  ) u_port1 (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .wdata    (wbyte_reg[5:0]),  // see RULE22
    .wr_data  (wr_p1d),
    .wr_dir   (wr_p1c),
    .wr_od    (1'b0),
    .stop_hiz ({6{hold_off}}),
    .pin_i    (port1_pin_i),
    .data_reg (p1_dat),          // see RULE5
    .dir_reg  (p1_dir),
    .od_reg   (),
    .rmw_val  (p1_rmw),
    .pin_o    (port1_pin_o),
    .pin_oe_n (port1_pin_oe_n)
  );

  // The stop-release bit floats in stop mode regardless of the hold enable.
  assign p2_hiz = {{2{hold_off}}, stop_mode};  // see RULE12

  // Port two has no direction register: every bit acts as open drain.
  gpio_port #(
    .W       (`GPIO_P2_W),
    .RST_DAT (`GPIO_P2_RST),
    .RST_DIR (`GPIO_P2_RST),
    .RST_OD  (`GPIO_P2_RST)
  ) u_port2 (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .wdata    (wbyte_reg[2:0]),  // see RULE22
    .wr_data  (wr_p2d),
    .wr_dir   (1'b0),
    .wr_od    (1'b0),
    .stop_hiz (p2_hiz),
    .pin_i    (port2_pin_i),
    .data_reg (p2_dat),          // see RULE7
    .dir_reg  (),
    .od_reg   (),
    .rmw_val  (p2_rmw),
    .pin_o    (port2_pin_o),
    .pin_oe_n (port2_pin_oe_n)
  );

  gpio_port #(
    .W       (`GPIO_P34_W),
    .RST_DAT (`GPIO_P34_RST),
    .RST_DIR (`GPIO_P34_RST),
    .RST_OD  (`GPIO_P34_RST)
  ) u_port3 (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .wdata    (wbyte_reg),
    .wr_data  (wr_p3d),
    .wr_dir   (wr_p3c),
    .wr_od    (wr_p3o),
    .stop_hiz ({8{hold_off}}),
    .pin_i    (port3_pin_i),
    .data_reg (p3_dat),          // see RULE13
    .dir_reg  (p3_dir),
    .od_reg   (p3_od),
    .rmw_val  (p3_rmw),
    .pin_o    (port3_pin_o),
    .pin_oe_n (port3_pin_oe_n)
  );

  gpio_port #(
    .W       (`GPIO_P34_W),
    .RST_DAT (`GPIO_P34_RST),
    .RST_DIR (`GPIO_P34_RST),
    .RST_OD  (`GPIO_P34_RST)
  ) u_port4 (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .wdata    (wbyte_reg),
    .wr_data  (wr_p4d),
    .wr_dir   (wr_p4c),
    .wr_od    (wr_p4o),
    .stop_hiz ({8{hold_off}}),
    .pin_i    (port4_pin_i),
    .data_reg (p4_dat),          // see RULE19
    .dir_reg  (p4_dir),
    .od_reg   (p4_od),           // see RULE20
    .rmw_val  (p4_rmw),
    .pin_o    (port4_pin_o),
    .pin_oe_n (port4_pin_oe_n)
  );

  // ****************************************************************************
  // Stop-release edge flag.
  // ****************************************************************************
  wire edge_flag;

  // The pin level is watched, so a pulse the port drives itself also counts.
  gpio_fall_flag u_stop_edge (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .level    (port2_pin_i[0]),  // see RULE11
    .clr      (wr_edge & wbyte_reg[0]),
    .flag_reg (edge_flag)
  );

  assign stop_release_irq = edge_flag;

  // ****************************************************************************
  // Read channel.
  // ****************************************************************************
  wire [12:0] ridx;
  wire        rmw;
  reg  [7:0]  rd_val;
  reg         rd_hit;

  assign ridx          = s_axi_araddr[14:2];
  assign rmw           = s_axi_araddr[`GPIO_RMW_BIT];
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = {24'h000000, rbyte_reg};

  // Pins are read live; the latch window serves the read-modify-write class.
  always @* begin
    rd_val = 8'h00;
    rd_hit = 1'b1;
    case (ridx)
      `GPIO_IDX_P1_DATA: begin
        rd_val = {2'b00, rmw ? p1_rmw : port1_pin_i};  // see RULE2, see RULE4, see RULE6
      end
      `GPIO_IDX_P2_DATA: begin
        rd_val = {5'b00000, rmw ? p2_rmw : port2_pin_i};  // see RULE9, see RULE10
      end
      `GPIO_IDX_P3_DATA: begin
        rd_val = rmw ? p3_rmw : port3_pin_i;  // see RULE16
      end
      `GPIO_IDX_P4_DATA: begin
        rd_val = rmw ? p4_rmw : port4_pin_i;  // see RULE16
      end
      `GPIO_IDX_P1_DIR: begin
        rd_val = {2'b00, p1_dir};
        rd_hit = ~rmw;
      end
      `GPIO_IDX_P3_DIR: begin
        rd_val = p3_dir;
        rd_hit = ~rmw;
      end
      `GPIO_IDX_P4_DIR: begin
        rd_val = p4_dir;
        rd_hit = ~rmw;
      end
      `GPIO_IDX_P3_OD: begin
        rd_val = p3_od;
        rd_hit = ~rmw;
      end
      `GPIO_IDX_P4_OD: begin
        rd_val = p4_od;
        rd_hit = ~rmw;
      end
      `GPIO_IDX_SYSCTL: begin
        rd_val = sysctl_reg;
        rd_hit = ~rmw;
      end
      `GPIO_IDX_EDGE: begin
        rd_val = {7'b0000000, edge_flag};
        rd_hit = ~rmw;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= `GPIO_RESP_OKAY;
      rbyte_reg  <= 8'h00;
    end else begin
      if (s_axi_arvalid && !rvalid_reg) begin
        rvalid_reg <= 1'b1;
        rresp_reg  <= rd_hit ? `GPIO_RESP_OKAY : `GPIO_RESP_SLVERR;
        rbyte_reg  <= rd_hit ? rd_val : 8'h00;  // see RULE1
      end else if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end
endmodule

/* gpio_ports_chk.sv */
// Concurrent checks on the ports of the general-purpose port block.
`timescale 1ns/10ps
`include "gpio_map.vh"
module gpio_ports_chk (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire [15:0] s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [2:0]  port2_pin_i,
  input wire [2:0]  port2_pin_o,
  input wire [2:0]  port2_pin_oe_n,
  input wire [7:0]  port3_pin_i,
  input wire [7:0]  port3_pin_o,
  input wire [7:0]  port3_pin_oe_n,
  input wire        stop_release_irq
);
  // ******
  // Capture of each read request and of the port three pins at that edge.
  // ******
  reg  [15:0] ar_reg;
  reg  [7:0]  pin_reg;
  wire [12:0] ar_idx = ar_reg[14:2];
  always @(posedge aclk) begin
    if (!aresetn) begin
      ar_reg  <= 16'h0000;
      pin_reg <= 8'h00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      ar_reg  <= s_axi_araddr;
      pin_reg <= port3_pin_i;
    end
  end
  // ******
  // Properties.
  // ******
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_wr_resp;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write answer off time");
  property p_rd_resp;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
  property p_rd_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
  property p_reset;
    $rose(aresetn) |-> port2_pin_o == 3'h7 && port3_pin_o == 8'h00 && (&port3_pin_oe_n);
  endproperty
  a_reset: assert property (p_reset) else $error("bad pin reset state");
  property p_p1_upper;
    s_axi_rvalid && ar_idx == `GPIO_IDX_P1_DATA |-> s_axi_rdata[31:6] == 26'h0000000;
  endproperty
  a_p1_upper: assert property (p_p1_upper) else $error("port one upper bits");
  property p_p2_upper;
    s_axi_rvalid && ar_idx == `GPIO_IDX_P2_DATA |-> s_axi_rdata[31:3] == 29'h00000000;
  endproperty
  a_p2_upper: assert property (p_p2_upper) else $error("port two upper bits");
  property p_rd_sample;
    s_axi_rvalid && !ar_reg[15] && ar_idx == `GPIO_IDX_P3_DATA
      |-> s_axi_rdata == {24'h000000, pin_reg};
  endproperty
  a_rd_sample: assert property (p_rd_sample) else $error("pin sample wrong");
  property p_pin_upd;
    $past(aresetn) && !$stable({port2_pin_o, port2_pin_oe_n, port3_pin_o, port3_pin_oe_n})
      |-> $rose(s_axi_bvalid);
  endproperty
  a_pin_upd: assert property (p_pin_upd) else $error("pin change off time");
  property p_irq_fall;
    $fell(port2_pin_i[0]) |=> stop_release_irq;
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("falling edge missed");
endmodule
bind gpio_ports gpio_ports_chk i_chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .port2_pin_i, .port2_pin_o, .port2_pin_oe_n,
  .port3_pin_i, .port3_pin_o, .port3_pin_oe_n, .stop_release_irq
);

/* gpio_ports_test.sv */
// Self-checking testbench of the general-purpose ports.
`timescale 1ns/10ps
`include "gpio_map.vh"
module gpio_ports_test;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready;
  logic [15:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire  [5:0]  port1_pin_i, port1_pin_o, port1_pin_oe_n;
  wire  [2:0]  port2_pin_i, port2_pin_o, port2_pin_oe_n;
  wire  [7:0]  port3_pin_i, port3_pin_o, port3_pin_oe_n;
  wire  [7:0]  port4_pin_i, port4_pin_o, port4_pin_oe_n;
  wire         stop_release_irq;
  logic [7:0]  ext_en [3];
  logic [7:0]  ext_v [3];
  logic [2:0]  p2_en, p2_v;
  logic [7:0]  seed;
  integer      n_errors, tests_run, cycles, i;
  logic [12:0] dat_idx [3] = '{`GPIO_IDX_P1_DATA, `GPIO_IDX_P3_DATA, `GPIO_IDX_P4_DATA};
  logic [12:0] dir_idx [3] = '{`GPIO_IDX_P1_DIR, `GPIO_IDX_P3_DIR, `GPIO_IDX_P4_DIR};
  logic [12:0] od_idx [3]  = '{13'h0000, `GPIO_IDX_P3_OD, `GPIO_IDX_P4_OD};
  logic [12:0] rst_idx [7] = '{`GPIO_IDX_P1_DIR, `GPIO_IDX_P3_DIR, `GPIO_IDX_P4_DIR,
    `GPIO_IDX_P3_OD, `GPIO_IDX_P4_OD, `GPIO_IDX_SYSCTL, `GPIO_IDX_EDGE};
  gpio_ports i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port1_pin_i, .port1_pin_o,
    .port1_pin_oe_n, .port2_pin_i, .port2_pin_o, .port2_pin_oe_n, .port3_pin_i,
    .port3_pin_o, .port3_pin_oe_n, .port4_pin_i, .port4_pin_o, .port4_pin_oe_n,
    .stop_release_irq);
  gpio_board #(.W(6)) i_b1 (.pin_o(port1_pin_o), .pin_oe_n(port1_pin_oe_n),
    .ext_en(ext_en[0][5:0]), .ext_v(ext_v[0][5:0]), .pin_i(port1_pin_i));
  gpio_board #(.W(3)) i_b2 (.pin_o(port2_pin_o), .pin_oe_n(port2_pin_oe_n),
    .ext_en(p2_en), .ext_v(p2_v), .pin_i(port2_pin_i));
  gpio_board #(.W(8)) i_b3 (.pin_o(port3_pin_o), .pin_oe_n(port3_pin_oe_n),
    .ext_en(ext_en[1]), .ext_v(ext_v[1]), .pin_i(port3_pin_i));
  gpio_board #(.W(8)) i_b4 (.pin_o(port4_pin_o), .pin_oe_n(port4_pin_oe_n),
    .ext_en(ext_en[2]), .ext_v(ext_v[2]), .pin_i(port4_pin_i));
  // ******
  // Helpers.
  // ******
  function automatic [7:0] nxt();
    seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
    return seed;
  endfunction
  function automatic [15:0] ad(input [12:0] idx);
    return {1'b0, idx, 2'b00};
  endfunction
  function automatic [7:0] drive_n(input [7:0] dir, input [7:0] od, input [7:0] dat);
    return ~(dir & (~od | ~dat));
  endfunction
  function automatic [15:0] pk(input integer k);
    case (k)
      0: return {2'b00, port1_pin_o, 2'b11, port1_pin_oe_n};
      1: return {port3_pin_o, port3_pin_oe_n};
      default: return {port4_pin_o, port4_pin_oe_n};
    endcase
  endfunction
  task automatic chk(input [31:0] got, input [31:0] exp, input string what);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input [15:0] a, input [7:0] d, input [1:0] er);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {nxt(), nxt(), nxt(), d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er, "write response");
  endtask
  task automatic rdc(input [15:0] a, input [1:0] er, input [31:0] exp);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk({s_axi_rresp, s_axi_rdata}, {er, exp}, "read answer");
  endtask
  task automatic trial(input integer k);
    logic [7:0] m, dat, dir, od, oe, pin, sel;
    m   = (k == 0) ? 8'h3F : 8'hFF;
    dat = nxt();
    dir = nxt();
    od  = (k == 0) ? 8'h00 : nxt();
    ext_en[k] <= nxt();
    ext_v[k]  <= nxt();
    wr(ad(dat_idx[k]), dat, `GPIO_RESP_OKAY);
    wr(ad(dir_idx[k]), dir, `GPIO_RESP_OKAY);
    wr(ad(od_idx[k]), od, (k == 0) ? `GPIO_RESP_SLVERR : `GPIO_RESP_OKAY);
    oe  = drive_n(dir, od, dat) | ~m;
    pin = ((~oe & dat) | (oe & ((ext_en[k] & ext_v[k]) | ~ext_en[k]))) & m;
    sel = dir | od;
    chk(pk(k), {dat & m, oe}, "pin drive");
    rdc(ad(dat_idx[k]), `GPIO_RESP_OKAY, {24'h0, pin});
    rdc(ad(dat_idx[k]) | 16'h8000, `GPIO_RESP_OKAY, {24'h0, ((sel & dat) | (~sel & pin)) & m});
    rdc(ad(dir_idx[k]), `GPIO_RESP_OKAY, {24'h0, dir & m});
  endtask
  task automatic wrap_up;
    $display("Comparisons: %0d, mismatches: %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ******
  // Stimulus.
  // ******
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      wrap_up();
    end
  end
  initial begin
    {seed, n_errors, tests_run, cycles} = {8'h5B, 96'h0};
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {64'h0, 4'hF};
    {p2_en, p2_v} = 6'h00;
    ext_en = '{8'h00, 8'h00, 8'h00};
    ext_v  = '{8'h00, 8'h00, 8'h00};
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 3; i++) chk(pk(i), 16'h00FF, "reset pins");
    chk({port2_pin_o, port2_pin_oe_n}, 6'h3F, "reset port two");
    for (i = 0; i < 7; i++) rdc(ad(rst_idx[i]), `GPIO_RESP_OKAY, 0);
    rdc(16'h0014, `GPIO_RESP_SLVERR, 0);
    rdc(ad(`GPIO_IDX_P3_DIR) | 16'h8000, `GPIO_RESP_SLVERR, 0);
    wr(ad(`GPIO_IDX_P3_DATA) | 16'h8000, 8'hFF, `GPIO_RESP_SLVERR);
    chk(pk(1), 16'h00FF, "refused write");
    for (i = 0; i < 30; i++) trial(i % 3);
    p2_en <= 3'h6;
    wr(ad(`GPIO_IDX_P2_DATA), 8'hFD, `GPIO_RESP_OKAY);
    chk({port2_pin_o, port2_pin_oe_n}, 6'h2D, "port two drive");
    rdc(ad(`GPIO_IDX_P2_DATA), `GPIO_RESP_OKAY, 1);
    rdc(ad(`GPIO_IDX_P2_DATA) | 16'h8000, `GPIO_RESP_OKAY, 5);
    wr(ad(`GPIO_IDX_P2_DATA), 8'h04, `GPIO_RESP_OKAY);
    @(posedge aclk);
    chk(stop_release_irq, 1, "edge flag");
    rdc(ad(`GPIO_IDX_EDGE), `GPIO_RESP_OKAY, 1);
    wr(ad(`GPIO_IDX_P2_DATA), 8'h07, `GPIO_RESP_OKAY);
    wr(ad(`GPIO_IDX_EDGE), 8'h01, `GPIO_RESP_OKAY);
    rdc(ad(`GPIO_IDX_EDGE), `GPIO_RESP_OKAY, 0);
    wr(ad(`GPIO_IDX_P3_DIR), 8'hFF, `GPIO_RESP_OKAY);
    wr(ad(`GPIO_IDX_P3_DATA), 8'h00, `GPIO_RESP_OKAY);
    wr(ad(`GPIO_IDX_P2_DATA), 8'h06, `GPIO_RESP_OKAY);
    wr(ad(`GPIO_IDX_SYSCTL), 8'h90, `GPIO_RESP_OKAY);
    chk({port2_pin_oe_n, port3_pin_oe_n}, 11'h700, "stop with hold");
    wr(ad(`GPIO_IDX_SYSCTL), 8'h80, `GPIO_RESP_OKAY);
    chk({port2_pin_oe_n, port3_pin_oe_n}, 11'h7FF, "stop released");
    wr(ad(`GPIO_IDX_SYSCTL), 8'h00, `GPIO_RESP_OKAY);
    chk({port2_pin_oe_n, port3_pin_oe_n}, 11'h600, "stop left");
    wr(ad(`GPIO_IDX_P2_DATA), 8'h07, `GPIO_RESP_OKAY);
    wr(ad(`GPIO_IDX_P4_DIR), 8'h80, `GPIO_RESP_OKAY);
    rdc(ad(`GPIO_IDX_P4_DIR), `GPIO_RESP_OKAY, 8'h80);
    wrap_up();
  end
endmodule
